/* pcc_pkg.sv */
// Package with the register map, field layout and state types of the PWM cycle configuration block.
package pcc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PCC_CFG_ADDR = 8'hf7;
    localparam int         PCC_NMOD     = 3;
    localparam logic [PCC_NMOD-1:0][7:0] PCC_CMP_LO_ADDR = {8'heb, 8'he9, 8'hfb};
    localparam logic [PCC_NMOD-1:0][7:0] PCC_CMP_HI_ADDR = {8'hec, 8'hea, 8'hfc};

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         PCC_SEL_BIT    = 7;
    localparam int         PCC_IEN_BIT    = 6;
    localparam int         PCC_FLAG_BIT   = 5;
    localparam int         PCC_LEN_LSB    = 0;
    localparam logic [7:0] PCC_CFG_RST    = 8'h00;
    localparam logic [15:0] PCC_CMP_RST   = 16'h0000;
    localparam logic [3:0] PCC_LEN_BASE   = 4'h8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PCC_LEN_8  = 2'b00,
        PCC_LEN_9  = 2'b01,
        PCC_LEN_10 = 2'b10,
        PCC_LEN_11 = 2'b11
    } pcc_len_t;

    typedef struct packed {
        logic       reload_reg_select;
        logic       cycle_ovf_irq_enable;
        logic       cycle_ovf_flag;
        pcc_len_t   cycle_length_select;
    } pcc_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcc_sfr_req_t;

    typedef struct packed {
        logic [PCC_NMOD-1:0] pwm_enable;
        logic [PCC_NMOD-1:0] wide_pwm_select;
    } pcc_mode_t;

    typedef struct packed {
        pcc_cfg_t                     cfg;
        logic [PCC_NMOD-1:0][15:0]    cmp;
        logic [PCC_NMOD-1:0][15:0]    rld;
        logic [7:0]                   rdata;
        logic                         ovf_pulse;
    } pcc_state_t;

endpackage

/* pcc_pwm_cycle.sv */
// PWM cycle length configuration, cycle overflow flag and compare/auto-reload register access.
module pcc_pwm_cycle (
    // Clock and reset
    input  wire logic                                   ref_clk_i,
    input  wire logic                                   sys_rst_i,
    // Special-function register access
    input  wire pcc_pkg::pcc_sfr_req_t                  sfr_req_i,
    output logic [7:0]                                  sfr_rdata_o,
    // Main counter and module modes
    input  wire logic [15:0]                            main_array_counter_i,
    input  wire logic                                   cnt_tick_i,
    input  wire pcc_pkg::pcc_mode_t                     mode_i,
    // Outputs toward the PWM generators
    output logic [3:0]                                  cycle_bits_o,
    output logic [pcc_pkg::PCC_NMOD-1:0][15:0]          module_compare_value_o,
    output logic                                        cycle_ovf_o,
    output logic                                        cycle_ovf_irq_o
);
    import pcc_pkg::*;

    pcc_state_t st_r;
    pcc_state_t st_nxt;
    logic       ovf_hit;
    logic [15:0] len_mask;
    logic [PCC_NMOD-1:0] use_short;

    // ------------------------------------------------------------
    // Cycle overflow detection
    // ------------------------------------------------------------
    // The counter value is the one before the tick, so an all-ones low field means it wraps on this tick.
    always_comb begin
        unique case (st_r.cfg.cycle_length_select)
            PCC_LEN_8:  len_mask = 16'h00ff;
            PCC_LEN_9:  len_mask = 16'h01ff;
            PCC_LEN_10: len_mask = 16'h03ff;
            PCC_LEN_11: len_mask = 16'h07ff;
        endcase
        ovf_hit = cnt_tick_i && ((main_array_counter_i & len_mask) == len_mask);
        for (int m = 0; m < PCC_NMOD; m++) begin
            use_short[m] = mode_i.pwm_enable[m] && !mode_i.wide_pwm_select[m];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ovf_pulse = ovf_hit;
        st_nxt.rdata = 8'h00;
        if (sfr_req_i.wr && sfr_req_i.addr == PCC_CFG_ADDR) begin
            st_nxt.cfg.reload_reg_select    = sfr_req_i.wdata[PCC_SEL_BIT];
            st_nxt.cfg.cycle_ovf_irq_enable = sfr_req_i.wdata[PCC_IEN_BIT];
            st_nxt.cfg.cycle_ovf_flag       = sfr_req_i.wdata[PCC_FLAG_BIT];
            st_nxt.cfg.cycle_length_select  = pcc_len_t'(sfr_req_i.wdata[PCC_LEN_LSB +: 2]);
        end
        // Hardware set wins over a software clear in the same cycle.
        if (ovf_hit) begin
            st_nxt.cfg.cycle_ovf_flag = 1'b1;
        end
        for (int m = 0; m < PCC_NMOD; m++) begin
            // A reload only matters once the cycle is longer than 8 bits.
            if (ovf_hit && use_short[m] && st_r.cfg.cycle_length_select != PCC_LEN_8) begin
                st_nxt.cmp[m] = st_r.rld[m];
            end
            if (sfr_req_i.wr && sfr_req_i.addr == PCC_CMP_LO_ADDR[m]) begin
                if (st_r.cfg.reload_reg_select) begin
                    st_nxt.rld[m][7:0] = sfr_req_i.wdata;
                end else begin
                    st_nxt.cmp[m][7:0] = sfr_req_i.wdata;
                end
            end
            if (sfr_req_i.wr && sfr_req_i.addr == PCC_CMP_HI_ADDR[m]) begin
                if (st_r.cfg.reload_reg_select) begin
                    st_nxt.rld[m][15:8] = sfr_req_i.wdata;
                end else begin
                    st_nxt.cmp[m][15:8] = sfr_req_i.wdata;
                end
            end
            if (sfr_req_i.rd && sfr_req_i.addr == PCC_CMP_LO_ADDR[m]) begin
                st_nxt.rdata = st_r.cfg.reload_reg_select ? st_r.rld[m][7:0] : st_r.cmp[m][7:0];
            end
            if (sfr_req_i.rd && sfr_req_i.addr == PCC_CMP_HI_ADDR[m]) begin
                st_nxt.rdata = st_r.cfg.reload_reg_select ? st_r.rld[m][15:8] : st_r.cmp[m][15:8];
            end
        end
        if (sfr_req_i.rd && sfr_req_i.addr == PCC_CFG_ADDR) begin
            st_nxt.rdata = {st_r.cfg.reload_reg_select, st_r.cfg.cycle_ovf_irq_enable,
                            st_r.cfg.cycle_ovf_flag, 3'h0, st_r.cfg.cycle_length_select};
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_r.cfg.reload_reg_select    <= PCC_CFG_RST[PCC_SEL_BIT];
            st_r.cfg.cycle_ovf_irq_enable <= PCC_CFG_RST[PCC_IEN_BIT];
            st_r.cfg.cycle_ovf_flag       <= PCC_CFG_RST[PCC_FLAG_BIT];
            st_r.cfg.cycle_length_select  <= pcc_len_t'(PCC_CFG_RST[PCC_LEN_LSB +: 2]);
            st_r.cmp       <= {PCC_NMOD{PCC_CMP_RST}};
            st_r.rld       <= {PCC_NMOD{PCC_CMP_RST}};
            st_r.rdata     <= 8'h00;
            st_r.ovf_pulse <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sfr_rdata_o            = st_r.rdata;
    assign module_compare_value_o = st_r.cmp;
    assign cycle_bits_o           = PCC_LEN_BASE + {2'h0, st_r.cfg.cycle_length_select};
    assign cycle_ovf_o            = st_r.ovf_pulse;
    assign cycle_ovf_irq_o        = st_r.cfg.cycle_ovf_flag && st_r.cfg.cycle_ovf_irq_enable;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Software strobe on the configuration register; several checks must leave that cycle out.
    logic cfg_wr;
    assign cfg_wr = sfr_req_i.wr && sfr_req_i.addr == PCC_CFG_ADDR;

    sequence s_cfg_read;
        sfr_req_i.rd && sfr_req_i.addr == PCC_CFG_ADDR;
    endsequence

    sequence s_cfg_write;
        cfg_wr;
    endsequence

    // An overflow edge on which software leaves the configuration register alone.
    sequence s_quiet_ovf;
        ovf_hit && !cfg_wr;
    endsequence

    // One cycle after an overflow the flag and the pulse are both up.
    sequence s_flag_up;
        st_r.cfg.cycle_ovf_flag && cycle_ovf_o;
    endsequence

    AST_IRQ_FOLLOWS_FLAG: assert property (
        s_quiet_ovf ##0 st_r.cfg.cycle_ovf_irq_enable |=> cycle_ovf_irq_o)
        else $error("Overflow with the enable set raised no interrupt request.");
    AST_IRQ_MASKED: assert property (
        !st_r.cfg.cycle_ovf_irq_enable |-> !cycle_ovf_irq_o)
        else $error("Interrupt raised while masked.");
    AST_FLAG_SET: assert property (
        ovf_hit |=> s_flag_up)
        else $error("Overflow did not set the flag.");
    AST_OVF_8BIT: assert property (
        cnt_tick_i && st_r.cfg.cycle_length_select == PCC_LEN_8
        && main_array_counter_i[7:0] == 8'hff |-> ovf_hit)
        else $error("8-bit cycle overflow missed.");
    AST_OVF_9BIT: assert property (
        cnt_tick_i && st_r.cfg.cycle_length_select == PCC_LEN_9
        && main_array_counter_i[8:0] == 9'h1ff |-> ovf_hit)
        else $error("9-bit cycle overflow missed.");
    AST_OVF_10BIT: assert property (
        st_r.cfg.cycle_length_select == PCC_LEN_10 && ovf_hit |-> main_array_counter_i[9:0] == 10'h3ff)
        else $error("10-bit overflow from wrong counter value.");
    AST_OVF_11BIT: assert property (
        st_r.cfg.cycle_length_select == PCC_LEN_11 && ovf_hit |-> main_array_counter_i[10:0] == 11'h7ff)
        else $error("11-bit overflow from wrong counter value.");
    AST_NO_OVF_IDLE: assert property (
        !cnt_tick_i |=> !cycle_ovf_o)
        else $error("Overflow pulse without a counter tick.");
    AST_FLAG_STICKY: assert property (
        st_r.cfg.cycle_ovf_flag && !cfg_wr |=> st_r.cfg.cycle_ovf_flag)
        else $error("Flag cleared without a software write.");
    AST_FLAG_SW_CLEAR: assert property (
        s_cfg_write ##0 (!sfr_req_i.wdata[PCC_FLAG_BIT] && !ovf_hit)
        |=> !st_r.cfg.cycle_ovf_flag)
        else $error("Software clear of the flag lost.");
    AST_FLAG_SW_SET: assert property (
        s_cfg_write ##0 sfr_req_i.wdata[PCC_FLAG_BIT] |=> st_r.cfg.cycle_ovf_flag)
        else $error("Software set of the flag lost.");
    AST_FLAG_SET_WINS: assert property (
        s_cfg_write ##0 ovf_hit |=> st_r.cfg.cycle_ovf_flag)
        else $error("Software clear beat a same-cycle overflow.");
    AST_UNUSED_ZERO: assert property (
        s_cfg_read |=> sfr_rdata_o[4:2] == 3'h0)
        else $error("Unused bits read nonzero.");
    AST_CYCLE_BITS: assert property (
        s_cfg_write |=> cycle_bits_o == PCC_LEN_BASE + {2'h0, $past(sfr_req_i.wdata[PCC_LEN_LSB +: 2])})
        else $error("Cycle length does not follow the written code.");
    AST_RELOAD_XFER: assert property (
        ovf_hit && use_short[0] && st_r.cfg.cycle_length_select != PCC_LEN_8
        && !sfr_req_i.wr |=> st_r.cmp[0] == $past(st_r.rld[0]))
        else $error("Reload value not transferred at cycle overflow.");
    AST_NO_RELOAD_8BIT: assert property (
        ovf_hit && st_r.cfg.cycle_length_select == PCC_LEN_8
        && !sfr_req_i.wr |=> st_r.cmp == $past(st_r.cmp))
        else $error("Reload applied in 8-bit mode.");
    AST_NO_RELOAD_IDLE: assert property (
        !mode_i.pwm_enable[2] && !sfr_req_i.wr |=> st_r.cmp[2] == $past(st_r.cmp[2]))
        else $error("Compare changed outside PWM mode.");
    AST_NO_RELOAD_WIDE: assert property (
        mode_i.wide_pwm_select[1] && !sfr_req_i.wr |=> st_r.cmp[1] == $past(st_r.cmp[1]))
        else $error("Compare changed in 16-bit mode.");
    AST_SEL_RELOAD_WR: assert property (
        sfr_req_i.wr && sfr_req_i.addr == PCC_CMP_LO_ADDR[2] && st_r.cfg.reload_reg_select
        |=> st_r.rld[2][7:0] == $past(sfr_req_i.wdata))
        else $error("Selected write did not reach the reload register.");
    AST_SEL_CMP_WR: assert property (
        sfr_req_i.wr && sfr_req_i.addr == PCC_CMP_HI_ADDR[0] && !st_r.cfg.reload_reg_select
        |=> st_r.cmp[0][15:8] == $past(sfr_req_i.wdata))
        else $error("Write did not reach the compare register.");
    AST_SEL_RELOAD_RD: assert property (
        sfr_req_i.rd && sfr_req_i.addr == PCC_CMP_LO_ADDR[1] && st_r.cfg.reload_reg_select
        |=> sfr_rdata_o == $past(st_r.rld[1][7:0]))
        else $error("Selected read did not return the reload register.");

endmodule

/* pcc_tb.sv */
// Self-checking testbench for the PWM cycle configuration block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pcc_pkg::*;

    logic                      ref_clk_i = 1'b0;
    logic                      sys_rst_i = 1'b1;
    pcc_sfr_req_t              sfr_req_i = '0;
    logic [7:0]                sfr_rdata_o;
    logic [15:0]               cnt_i     = 16'h0000;
    logic                      tick_i    = 1'b0;
    pcc_mode_t                 mode_i    = '0;
    logic [3:0]                cycle_bits_o;
    logic [PCC_NMOD-1:0][15:0] cmp_o;
    logic                      ovf_o;
    logic                      irq_o;
    int                        num_errors  = 0;
    int                        checks_done = 0;
    int                        seed        = 32'hb94f;
    int                        cfg         = 0;
    int                        cmp[3]      = '{0, 0, 0};
    int                        rld[3]      = '{0, 0, 0};

    always #5 ref_clk_i = ~ref_clk_i;

    pcc_pwm_cycle i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sfr_req_i(sfr_req_i),
        .sfr_rdata_o(sfr_rdata_o), .main_array_counter_i(cnt_i), .cnt_tick_i(tick_i), .mode_i(mode_i),
        .cycle_bits_o(cycle_bits_o), .module_compare_value_o(cmp_o), .cycle_ovf_o(ovf_o), .cycle_ovf_irq_o(irq_o));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic outs();
        chk(cycle_bits_o, 8 + cfg[1:0]);
        chk(irq_o, cfg[5] & cfg[6]);
        for (int m = 0; m < 3; m++) chk(cmp_o[m], cmp[m][15:0]);
    endtask

    // Requests change just after an edge and are taken at the next one.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_req_i <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk_i);
        sfr_req_i <= '0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int sh;
        for (int m = 0; m < 3; m++) begin
            sh = (a == PCC_CMP_HI_ADDR[m]) ? 8 : 0;
            if (a == PCC_CMP_LO_ADDR[m] || a == PCC_CMP_HI_ADDR[m]) begin
                if (cfg[7]) rld[m] = (rld[m] & ~(255 << sh)) | (d << sh);
                else cmp[m] = (cmp[m] & ~(255 << sh)) | (d << sh);
            end
        end
        if (a == PCC_CFG_ADDR) cfg = d & 8'he3;
        bus(1'b1, a, d);
        outs();
    endtask

    task automatic rd(input logic [7:0] a);
        int exp;
        exp = (a == PCC_CFG_ADDR) ? cfg : 0;
        for (int m = 0; m < 3; m++) begin
            if (a == PCC_CMP_LO_ADDR[m]) exp = (cfg[7] ? rld[m] : cmp[m]) & 255;
            if (a == PCC_CMP_HI_ADDR[m]) exp = (cfg[7] ? rld[m] : cmp[m]) >> 8;
        end
        bus(1'b0, a, 8'h00);
        chk(sfr_rdata_o, exp[7:0]);
    endtask

    task automatic tick(input logic [15:0] c);
        int  mask;
        logic ov;
        @(posedge ref_clk_i);
        cnt_i <= c;
        tick_i <= 1'b1;
        mode_i <= 6'($random(seed));
        @(posedge ref_clk_i);
        tick_i <= 1'b0;
        #1;
        mask = (1 << (8 + cfg[1:0])) - 1;
        ov = (c & mask) == mask;
        chk(ovf_o, ov);
        if (ov) begin
            cfg = cfg | 32'h20;
            for (int m = 0; m < 3; m++) begin
                if (mode_i.pwm_enable[m] && !mode_i.wide_pwm_select[m] && cfg[1:0] != 0) cmp[m] = rld[m];
            end
        end
        outs();
    endtask

    // An overflow and a software clear of the flag on one edge: the hardware set must win.
    task automatic clash();
        @(posedge ref_clk_i);
        cnt_i     <= 16'hffff;
        tick_i    <= 1'b1;
        mode_i    <= '0;
        sfr_req_i <= '{wr: 1'b1, rd: 1'b0, addr: PCC_CFG_ADDR, wdata: 8'h40};
        @(posedge ref_clk_i);
        tick_i    <= 1'b0;
        sfr_req_i <= '0;
        #1;
        cfg = 32'h60;
        chk(ovf_o, 1'b1);
        outs();
    endtask

    initial begin
        int m;
        logic [7:0] a;
        repeat (20) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        outs();
        rd(PCC_CFG_ADDR);
        wr(PCC_CFG_ADDR, 8'hff);
        rd(PCC_CFG_ADDR);
        wr(PCC_CFG_ADDR, 8'h00);
        rd(8'hf6);
        $display("Reset and register test done");
        for (int i = 0; i < 300; i++) begin
            m = {$random(seed)} % 3;
            a = $random(seed) & 1 ? PCC_CMP_HI_ADDR[m] : PCC_CMP_LO_ADDR[m];
            wr(PCC_CFG_ADDR, 8'($random(seed)));
            wr(a, 8'($random(seed)));
            rd(a);
            if (i % 5 == 0) wr(8'hf6, 8'hff);
            if (i % 3 == 0) tick(16'($random(seed)) | 16'h07ff);
            else if (i % 3 == 1) tick(16'((1 << (8 + cfg[1:0])) - 2));
            else tick(16'($random(seed)));
            rd(PCC_CFG_ADDR);
        end
        $display("Random overflow and reload test done");
        clash();
        rd(PCC_CFG_ADDR);
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        cfg = 0;
        cmp = '{0, 0, 0};
        rld = '{0, 0, 0};
        chk(ovf_o, 1'b0);
        outs();
        wr(PCC_CFG_ADDR, 8'h80);
        rd(PCC_CMP_HI_ADDR[0]);
        $display("Collision and mid-run reset test done");
        conclude();
    end
endmodule
